/* File: iot_osc_ctrl.sv */
// module: internal oscillator trim, frequency select and multiplier enable control
//
// Design decisions made here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

// What this block and the software driving it do
// RULE1: six-bit signed trim, resets to zero
// RULE2: trim code monotonic to fast oscillator frequency
// RULE3: write starts shift, no completion flag
// RULE4: trim never touches slow oscillator
// RULE5: bit 7 picks fast/512 or slow
// RULE6: bit 6 enables x4 at 8/16 MHz
// RULE7: enable bit forced zero unless internal mode
// RULE8: slow oscillator enable conditions
// RULE9: timers and monitor run on slow oscillator
// RULE10: three-bit select picks one of eight
// RULE11: frequency select resets to 011
// RULE12: select field in bits 6 to 4
// RULE13: crystal x4 mode at config 0110
// RULE14: crystal x4 ignores software enable
// RULE15: internal mode multiplier needs bit and freq
// RULE16: software adjusts trim on serial errors
// RULE17: software adjusts trim from timer compare
// RULE18: software adjusts trim from capture interval
// RULE19: fast oscillator enable conditions
// RULE20: readable fast oscillator stable flag
// RULE21: effective enable is AND of conditions
// RULE22: trim output updates on write edge
module iot_osc_ctrl
(
  input  wire logic                core_clk,
  input  wire logic                nrst,
  input  wire logic                clk_en,
  input  wire logic [3:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic [31:0]              avs_readdata,
  output logic                     avs_waitrequest,
  input  wire logic [3:0]          primary_osc_config,
  input  wire logic                powerup_delay_timer_en,
  input  wire logic                watchdog_counter_en,
  input  wire logic                clock_fail_monitor_en,
  input  wire logic                fast_osc_ready_pin,
  output iot_pkg::iot_clk_ctl_t    clk_ctl,
  output logic                     slow_clk_users_sel
);
  import iot_pkg::*;

  typedef enum logic [1:0] {
    IOT_IDLE = 2'b00,
    IOT_ACK  = 2'b01
  } iot_bus_st_t;

  iot_bus_st_t   bus_reg;
  iot_bus_st_t   bus_next;
  iot_trim_t     trim_reg;
  logic [2:0]    fsel_reg;
  logic          sys_hi_reg;
  logic [31:0]   rdata_reg;
  logic [9:0]    div_reg;
  logic          lf_tick_reg;
  logic [3:0]    stab_cnt_reg;
  logic          stable_reg;
  logic          rdy_s1_reg;
  logic          rdy_s2_reg;
  iot_clk_ctl_t  ctl_reg;
  logic          slow_users_reg;
  logic          wait_reg;

  function automatic logic sel_hit(input logic [3:0] a, input logic [3:0] want);
    sel_hit = (a == want);
  endfunction

  wire logic       acc       = (avs_read | avs_write) & (bus_reg == IOT_IDLE);
  // writes commit on the edge where the master sees waitrequest low, not before
  wire logic       done      = (bus_reg == IOT_ACK);
  wire logic       wr_trim   = done & avs_write & sel_hit(avs_address, ADDR_TRIM_CTRL)
                               & avs_byteenable[0];
  wire logic       wr_osc    = done & avs_write & sel_hit(avs_address, ADDR_OSC_CTRL)
                               & avs_byteenable[0];
  // see RULE7
  wire logic       int_mode  = (primary_osc_config[3:1] == CFG_INT_PREFIX);
  wire logic       xtal_x4   = (primary_osc_config == CFG_XTAL_X4); // see RULE13
  wire logic       hi_freq   = (fsel_reg == FSEL_16M) | (fsel_reg == FSEL_8M);
  // see RULE15 see RULE21 see RULE6
  wire logic       mult_int  = trim_reg.mult_en & int_mode & hi_freq;
  // see RULE14
  wire logic       mult_eff  = xtal_x4 | mult_int;
  // see RULE19
  wire logic       fast_en   = sys_hi_reg & ((fsel_reg != FSEL_LOW) | trim_reg.lf_src);
  wire logic       timers_on = powerup_delay_timer_en | watchdog_counter_en
                               | clock_fail_monitor_en;
  // see RULE8
  wire logic       slow_en   = ((fsel_reg == FSEL_LOW) & ~trim_reg.lf_src) | timers_on;
  // see RULE7: enable bit reads zero where it has no function
  wire logic [7:0] trim_rd   = {trim_reg.lf_src, mult_int, trim_reg.trim};
  wire logic [7:0] osc_rd    = {1'b0, fsel_reg, 2'b00, sys_hi_reg, 1'b0};
  wire logic [7:0] stat_rd   = {4'h0, stable_reg, mult_eff, slow_en, fast_en};
  wire logic [31:0] rd_mux   =
    sel_hit(avs_address, ADDR_TRIM_CTRL) ? {24'h00_0000, trim_rd} :
    sel_hit(avs_address, ADDR_OSC_CTRL)  ? {24'h00_0000, osc_rd}  :
    sel_hit(avs_address, ADDR_STATUS)    ? {24'h00_0000, stat_rd} : RDATA_UNMAPPED;
  wire logic [3:0] stab_inc  = stab_cnt_reg + 4'h1;

  always_comb begin
    bus_next = IOT_IDLE;
    if (clk_en && acc) begin
      bus_next = IOT_ACK;
    end
  end

  // one wait cycle, answer on second edge
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bus_reg   <= IOT_IDLE;
      rdata_reg <= 32'h0000_0000;
      wait_reg  <= 1'b1;
    end else if (clk_en) begin
      bus_reg <= bus_next;
      // registered so the master never sees a decode glitch
      wait_reg <= (bus_next != IOT_ACK);
      if (acc && avs_read) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  // see RULE1 see RULE11 see RULE12 see RULE22
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      trim_reg   <= TRIM_CTRL_RESET;
      fsel_reg   <= FSEL_RESET;
      sys_hi_reg <= 1'b0;
    end else if (clk_en) begin
      if (wr_trim) begin
        trim_reg <= avs_writedata[7:0];
      end
      if (wr_osc) begin
        fsel_reg   <= avs_writedata[FSEL_LSB +: FSEL_W];
        sys_hi_reg <= avs_writedata[SYS_HI_BIT];
      end
    end
  end

  // see RULE5: fast/512 tick for the low-frequency option
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      div_reg     <= 10'h000;
      lf_tick_reg <= 1'b0;
    end else if (clk_en) begin
      div_reg     <= (div_reg == LF_DIV_LAST) ? 10'h000 : div_reg + 10'h001;
      lf_tick_reg <= trim_reg.lf_src & (div_reg == LF_DIV_LAST);
    end
  end

  // ready pin from analogue side is asynchronous
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdy_s1_reg   <= 1'b0;
      rdy_s2_reg   <= 1'b0;
      stab_cnt_reg <= 4'h0;
      stable_reg   <= 1'b0;
    end else if (clk_en) begin
      rdy_s1_reg <= fast_osc_ready_pin;
      rdy_s2_reg <= rdy_s1_reg;
      // see RULE20: filtered so glitches on ready do not flag stable
      if (!rdy_s2_reg || !fast_en) begin
        stab_cnt_reg <= 4'h0;
        stable_reg   <= 1'b0;
      end else if (stab_cnt_reg != STABLE_CYCLES) begin
        stab_cnt_reg <= stab_inc;
      end else begin
        stable_reg <= 1'b1;
      end
    end
  end

  // see RULE2 see RULE3 see RULE4 see RULE9 see RULE10
  // trim goes straight to the analogue trim; no shift-complete flag exists
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctl_reg        <= '0;
      // low in reset, high from the first enabled edge
      slow_users_reg <= 1'b0;
    end else if (clk_en) begin
      ctl_reg.fast_en <= fast_en;
      ctl_reg.slow_en <= slow_en;
      ctl_reg.mult_en <= mult_eff;
      ctl_reg.lf_tick <= lf_tick_reg;
      ctl_reg.fsel    <= fsel_reg;
      ctl_reg.trim    <= wr_trim ? avs_writedata[5:0] : trim_reg.trim;
      slow_users_reg  <= 1'b1;
    end
  end

  assign clk_ctl            = ctl_reg;
  assign slow_clk_users_sel = slow_users_reg;
  assign avs_readdata       = rdata_reg;
  assign avs_waitrequest    = wait_reg;

  property p_mult_forced;
    @(posedge core_clk) disable iff (!nrst)
      clk_en && !int_mode && !xtal_x4 |=> !ctl_reg.mult_en;
  endproperty
  a_mult_forced: assert property (p_mult_forced) else $error("multiplier on in wrong mode"); // see RULE7

  property p_xtal;
    @(posedge core_clk) disable iff (!nrst) clk_en && xtal_x4 |=> ctl_reg.mult_en;
  endproperty
  a_xtal: assert property (p_xtal) else $error("crystal x4 not enabled"); // see RULE14

  property p_int_mult;
    @(posedge core_clk) disable iff (!nrst)
      clk_en && int_mode && !hi_freq |=> !ctl_reg.mult_en;
  endproperty
  a_int_mult: assert property (p_int_mult) else $error("multiplier at low freq"); // see RULE15

  property p_trim_upd;
    @(posedge core_clk) disable iff (!nrst)
      clk_en && wr_trim |=> ctl_reg.trim == $past(avs_writedata[5:0]);
  endproperty
  a_trim_upd: assert property (p_trim_upd) else $error("trim not updated"); // see RULE22

  property p_slow;
    @(posedge core_clk) disable iff (!nrst) clk_en && timers_on |=> ctl_reg.slow_en;
  endproperty
  a_slow: assert property (p_slow) else $error("slow osc off with timers"); // see RULE8

  property p_fast;
    @(posedge core_clk) disable iff (!nrst) clk_en && !sys_hi_reg |=> !ctl_reg.fast_en;
  endproperty
  a_fast: assert property (p_fast) else $error("fast osc on without select"); // see RULE19

  property p_rd_mult;
    @(posedge core_clk) disable iff (!nrst) !int_mode |-> !trim_rd[MULT_EN_BIT];
  endproperty
  a_rd_mult: assert property (p_rd_mult) else $error("enable bit reads one"); // see RULE7

  property p_ack;
    @(posedge core_clk) disable iff (!nrst)
      clk_en && acc |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer timing wrong"); // see RULE1

  property p_wait_one;
    @(posedge core_clk) disable iff (!nrst)
      clk_en && !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long"); // see RULE1

  property p_trim_rd;
    @(posedge core_clk) disable iff (!nrst)
      clk_en && acc && avs_read && sel_hit(avs_address, ADDR_TRIM_CTRL)
      |=> avs_readdata[TRIM_LSB +: TRIM_W] == $past(trim_reg.trim);
  endproperty
  a_trim_rd: assert property (p_trim_rd) else $error("trim read wrong"); // see RULE1

  property p_fsel_out;
    @(posedge core_clk) disable iff (!nrst)
      clk_en |=> ctl_reg.fsel == $past(fsel_reg);
  endproperty
  a_fsel_out: assert property (p_fsel_out) else $error("select not passed on"); // see RULE10

  property p_stab_off;
    @(posedge core_clk) disable iff (!nrst)
      clk_en && !fast_en |=> !stable_reg;
  endproperty
  a_stab_off: assert property (p_stab_off) else $error("stable while fast osc off"); // see RULE20

  property p_lf_off;
    @(posedge core_clk) disable iff (!nrst)
      clk_en && !trim_reg.lf_src |=> !lf_tick_reg;
  endproperty
  a_lf_off: assert property (p_lf_off) else $error("divided tick with slow source"); // see RULE5

  property p_trim_hold;
    @(posedge core_clk) disable iff (!nrst)
      clk_en && !wr_trim |=> ctl_reg.trim == $past(trim_reg.trim);
  endproperty
  a_trim_hold: assert property (p_trim_hold) else $error("trim moved without write"); // see RULE22

  property p_users;
    @(posedge core_clk) disable iff (!nrst)
      clk_en |=> slow_clk_users_sel;
  endproperty
  a_users: assert property (p_users) else $error("timers not on slow osc"); // see RULE9

  property p_slow_off;
    @(posedge core_clk) disable iff (!nrst)
      clk_en && !timers_on && ((fsel_reg != FSEL_LOW) || trim_reg.lf_src) |=> !ctl_reg.slow_en;
  endproperty
  a_slow_off: assert property (p_slow_off) else $error("slow osc on without cause"); // see RULE8

  property p_fast_on;
    @(posedge core_clk) disable iff (!nrst)
      clk_en && sys_hi_reg && (fsel_reg != FSEL_LOW) |=> ctl_reg.fast_en;
  endproperty
  a_fast_on: assert property (p_fast_on) else $error("fast osc off when selected"); // see RULE19

  property p_mult_on;
    @(posedge core_clk) disable iff (!nrst)
      clk_en && int_mode && hi_freq && trim_reg.mult_en |=> ctl_reg.mult_en;
  endproperty
  a_mult_on: assert property (p_mult_on) else $error("internal multiplier not on"); // see RULE15

  c_wr: cover property (@(posedge core_clk) disable iff (!nrst) wr_trim);
  c_mult: cover property (@(posedge core_clk) disable iff (!nrst) mult_int);
  c_stable: cover property (@(posedge core_clk) disable iff (!nrst) stable_reg);
  c_lf: cover property (@(posedge core_clk) disable iff (!nrst) lf_tick_reg);
  c_freeze: cover property (@(posedge core_clk) disable iff (!nrst) !clk_en);
endmodule
`default_nettype wire

/* File: iot_pkg.sv */
// package: register map, fields, resets and encodings of the oscillator trim block
package iot_pkg;
  localparam logic [3:0] ADDR_TRIM_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_OSC_CTRL    = 4'h1;
  localparam logic [3:0] ADDR_STATUS      = 4'h2;
  localparam int         TRIM_LSB         = 0;
  localparam int         TRIM_W           = 6;
  localparam int         MULT_EN_BIT      = 6;
  localparam int         LF_SRC_BIT       = 7;
  localparam int         FSEL_LSB         = 4;
  localparam int         FSEL_W           = 3;
  localparam int         SYS_HI_BIT       = 1;
  localparam int         ST_FAST_RUN_BIT  = 0;
  localparam int         ST_SLOW_RUN_BIT  = 1;
  localparam int         ST_MULT_RUN_BIT  = 2;
  localparam int         ST_STABLE_BIT    = 3;
  localparam logic [7:0] TRIM_CTRL_RESET  = 8'h00;
  localparam logic [2:0] FSEL_RESET       = 3'h3;
  localparam logic [2:0] FSEL_16M         = 3'h7;
  localparam logic [2:0] FSEL_8M          = 3'h6;
  localparam logic [2:0] FSEL_LOW         = 3'h0;
  localparam logic [3:0] CFG_XTAL_X4      = 4'h6;
  localparam logic [2:0] CFG_INT_PREFIX   = 3'h4;
  localparam logic [9:0] LF_DIV           = 10'h200;
  localparam logic [9:0] LF_DIV_LAST      = 10'h1ff;
  localparam logic [3:0] STABLE_CYCLES    = 4'h8;
  localparam logic [31:0] RDATA_UNMAPPED  = 32'h0000_0000;

  typedef struct packed {
    logic       lf_src;
    logic       mult_en;
    logic [5:0] trim;
  } iot_trim_t;

  typedef struct packed {
    logic       fast_en;
    logic       slow_en;
    logic       mult_en;
    logic       lf_tick;
    logic [2:0] fsel;
    logic [5:0] trim;
  } iot_clk_ctl_t;
endpackage

/* File: tb.sv */
// testbench: random and corner checks of the oscillator trim block over its register bus
`timescale 1ns/10ps
`default_nettype none
module tb;
  import iot_pkg::*;
  logic         core_clk = 1'b0;
  logic         nrst = 1'b0;
  logic [3:0]   avs_address = 4'h0;
  logic         avs_read = 1'b0;
  logic         avs_write = 1'b0;
  logic [31:0]  avs_writedata = 32'h0000_0000;
  logic [3:0]   avs_byteenable = 4'h0;
  logic [31:0]  avs_readdata;
  logic         avs_waitrequest;
  logic [3:0]   cfg = 4'h8;
  logic [2:0]   ten = 3'h0;
  logic         rdy = 1'b0;
  logic         ce = 1'b1;
  iot_clk_ctl_t clk_ctl;
  logic         slow_sel;
  int           miscompares = 0;
  int           n_checks = 0;
  logic [31:0]  rd;
  always #2.5 core_clk = ~core_clk;
  iot_osc_ctrl i_iot_osc_ctrl (
    .core_clk(core_clk), .nrst(nrst), .clk_en(ce),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .primary_osc_config(cfg), .powerup_delay_timer_en(ten[0]),
    .watchdog_counter_en(ten[1]), .clock_fail_monitor_en(ten[2]),
    .fast_osc_ready_pin(rdy), .clk_ctl(clk_ctl), .slow_clk_users_sel(slow_sel)
  );
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int n;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      miscompares++;
      summarize();
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  function automatic logic [7:0] trim_step(logic [7:0] v, logic up);
    return {v[7:6], up ? v[5:0] + 6'h01 : v[5:0] - 6'h01};
  endfunction
  function automatic logic pll_int(logic [3:0] c, logic [2:0] fs, logic b);
    return c[3:1] == CFG_INT_PREFIX && b && (fs == FSEL_16M || fs == FSEL_8M);
  endfunction
  initial begin
    int i;
    int n;
    logic [7:0] t;
    logic [2:0] f;
    logic s;
    logic fe;
    logic me;
    logic se;
    void'($urandom(32'hef28));
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    for (i = 0; i < 90; i++) begin
      if (i == 80) begin
        nrst <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk("wait_rst", avs_waitrequest, 1'b1);
        chk("users_rst", slow_sel, 1'b0);
        chk("ctl_rst", clk_ctl, 32'h0000_0000);
        nrst <= 1'b1;
      end
      if (i == 0 || i == 80) begin
        bus(1'b0, ADDR_TRIM_CTRL, 32'h0, 4'hf);
        chk("trim_reset", rd, {24'h0, TRIM_CTRL_RESET});
        bus(1'b0, ADDR_OSC_CTRL, 32'h0, 4'hf);
        chk("fsel_reset", rd[6:4], FSEL_RESET);
        chk("slow_users", slow_sel, 1'b1);
        bus(1'b0, 4'hf, 32'h0, 4'hf);
        chk("unmapped", rd, RDATA_UNMAPPED);
      end
      t = 8'($urandom());
      f = (i < 16) ? 3'(i) : 3'($urandom());
      s = 1'($urandom());
      // corner codes: most positive and most negative trim
      if (i == 1) t[5:0] = 6'h1f;
      if (i == 2) t[5:0] = 6'h20;
      cfg <= (i % 4 == 0) ? CFG_XTAL_X4 : (i % 4 == 1) ? 4'h8 : (i % 4 == 2) ? 4'h9
             : 4'($urandom());
      ten <= (i % 3 == 0) ? 3'h0 : 3'($urandom());
      rdy <= (i % 5 != 0);
      bus(1'b1, ADDR_OSC_CTRL, {24'h0, 1'b0, f, 2'b00, s, 1'b0}, 4'h1);
      bus(1'b1, ADDR_TRIM_CTRL, {24'h0, t}, 4'h1);
      // lane 0 disabled: must leave trim alone
      bus(1'b1, ADDR_TRIM_CTRL, {24'h0, ~t}, 4'he);
      bus(1'b1, ADDR_STATUS, 32'h0000_00ff, 4'h1);
      repeat (14) @(posedge core_clk);
      chk("mult", clk_ctl.mult_en, cfg == CFG_XTAL_X4 || pll_int(cfg, f, t[6]));
      chk("trim_out", clk_ctl.trim, t[5:0]);
      chk("fsel_out", clk_ctl.fsel, f);
      chk("slow", clk_ctl.slow_en, (f == FSEL_LOW && !t[7]) || ten != 3'h0);
      fe = s && (f != FSEL_LOW || t[7]);
      me = cfg == CFG_XTAL_X4 || pll_int(cfg, f, t[6]);
      se = (f == FSEL_LOW && !t[7]) || ten != 3'h0;
      bus(1'b0, ADDR_TRIM_CTRL, 32'h0, 4'h1);
      chk("trim_rd", rd, {24'h0, t[7], pll_int(cfg, f, t[6]), t[5:0]});
      bus(1'b0, ADDR_STATUS, 32'h0, 4'h1);
      chk("fast", clk_ctl.fast_en, fe);
      chk("status", rd, {28'h0, rdy && fe, me, se, fe});
    end
    // low-frequency tick from the fast oscillator divided down
    bus(1'b1, ADDR_TRIM_CTRL, 32'h0000_0080, 4'h1);
    n = 0;
    while (clk_ctl.lf_tick !== 1'b1 && n < 600) begin
      @(posedge core_clk);
      n++;
    end
    @(posedge core_clk);
    n = 1;
    while (clk_ctl.lf_tick !== 1'b1 && n < 600) begin
      @(posedge core_clk);
      n++;
    end
    chk("lf_period", n, LF_DIV);
    // clock enable low for 8 edges stretches one divider period by 8
    @(posedge core_clk);
    ce <= 1'b0;
    repeat (8) @(posedge core_clk);
    ce <= 1'b1;
    n = 9;
    while (clk_ctl.lf_tick !== 1'b1 && n < 600) begin
      @(posedge core_clk);
      n++;
    end
    chk("lf_freeze", n, LF_DIV + 10'h008);
    // software trim steps: down for a fast clock, up for a slow one
    bus(1'b0, ADDR_TRIM_CTRL, 32'h0, 4'h1);
    t = trim_step(rd[7:0], 1'b0);
    bus(1'b1, ADDR_TRIM_CTRL, {24'h0, t}, 4'h1);
    @(posedge core_clk);
    chk("trim_dec", clk_ctl.trim, 6'h3f);
    t = trim_step(t, 1'b0);
    bus(1'b1, ADDR_TRIM_CTRL, {24'h0, t}, 4'h1);
    @(posedge core_clk);
    chk("trim_dec2", clk_ctl.trim, 6'h3e);
    t = trim_step(t, 1'b1);
    bus(1'b1, ADDR_TRIM_CTRL, {24'h0, t}, 4'h1);
    @(posedge core_clk);
    chk("trim_inc", clk_ctl.trim, 6'h3f);
    summarize();
  end
endmodule
`default_nettype wire
